// ==== logic/ndc_pkg.sv ====
/*
 * Constants, register map, field positions and types for the data
 * EEPROM access controller.
 * Assumes a 200 MHz core clock and a 32-bit AHB-Lite register bus.
 */
`default_nettype none

package ndc_pkg;

    // ************************************************************
    // Clock and write timing
    // ************************************************************
    localparam int unsigned CLK_PERIOD_PS = 5000;
    // Array write time; the array's true figure is set per part
    localparam int unsigned WRITE_TIME_NS = 1000;
    localparam int unsigned WRITE_CYCLES =
        (WRITE_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

    // ************************************************************
    // Array geometry
    // ************************************************************
    localparam int unsigned DATA_W = 8;
    localparam int unsigned IDX_W = 8;
    localparam int unsigned DEPTH = 256;

    // ************************************************************
    // Register indices; byte address is four times the index
    // ************************************************************
    localparam int unsigned ADDR_W = 14;
    localparam logic [11:0] IDX_DONE = 12'h00C;
    localparam logic [11:0] IDX_VALUE_LOW = 12'h10C;
    localparam logic [11:0] IDX_INDEX_LOW = 12'h10D;
    localparam logic [11:0] IDX_CONTROL = 12'h18C;
    localparam logic [11:0] IDX_UNLOCK = 12'h18D;
    localparam logic [13:0] ADDR_DONE = {IDX_DONE, 2'h0};
    localparam logic [13:0] ADDR_VALUE_LOW = {IDX_VALUE_LOW, 2'h0};
    localparam logic [13:0] ADDR_INDEX_LOW = {IDX_INDEX_LOW, 2'h0};
    localparam logic [13:0] ADDR_CONTROL = {IDX_CONTROL, 2'h0};
    localparam logic [13:0] ADDR_UNLOCK = {IDX_UNLOCK, 2'h0};

    // ************************************************************
    // Field positions
    // ************************************************************
    localparam int unsigned BIT_SELECT = 7;
    localparam int unsigned BIT_ERROR = 3;
    localparam int unsigned BIT_PERMIT = 2;
    localparam int unsigned BIT_WRITE = 1;
    localparam int unsigned BIT_READ = 0;
    localparam int unsigned BIT_DONE = 7;

    // ************************************************************
    // Reset values and unlock keys
    // ************************************************************
    localparam logic [7:0] VALUE_RESET = 8'h00;
    localparam logic [7:0] INDEX_RESET = 8'h00;
    localparam logic SELECT_RESET = 1'b0;
    localparam logic PERMIT_RESET = 1'b0;
    localparam logic ERROR_RESET = 1'b0;
    localparam logic DONE_RESET = 1'b0;
    localparam logic [7:0] KEY_FIRST = 8'h55;
    localparam logic [7:0] KEY_SECOND = 8'hAA;

    typedef enum logic [1:0] {
        UNL_IDLE,
        UNL_FIRST,
        UNL_ARMED
    } ndc_unlock_t;

endpackage

`default_nettype wire

// ==== logic/ndc_mem_if.sv ====
/*
 * Carrier between the controller and the array with its write timer.
 * Assumes both ends run on the same clock.
 */
`timescale 1ns/10ps
`default_nettype none

interface ndc_mem_if #(
    parameter int unsigned IDX_W = 8,
    parameter int unsigned DATA_W = 8
);
    logic start;
    logic abort;
    logic [IDX_W-1:0] index;
    logic [DATA_W-1:0] wdata;
    logic [DATA_W-1:0] rdata;
    logic busy;
    logic done;

    modport ctrl (output start, output abort, output index, output wdata,
                  input rdata, input busy, input done);
    modport mem (input start, input abort, input index, input wdata,
                 output rdata, output busy, output done);
endinterface

`default_nettype wire

// ==== logic/ndc_array.sv ====
/*
 * Data byte array in flip-flops with its write-cycle timer.
 * Assumes start is only raised while busy is low.
 */
`timescale 1ns/10ps
`default_nettype none

module ndc_array
    import ndc_pkg::*;
#(
    parameter int unsigned WRITE_CYCLES_P = ndc_pkg::WRITE_CYCLES
)
(
    input wire logic clk,
    input wire logic rst_n,
    ndc_mem_if.mem mem
);
    localparam int unsigned CNT_W = $clog2(WRITE_CYCLES_P + 1);

    initial
    begin
        if (WRITE_CYCLES_P < 1 || DEPTH > (1 << IDX_W))
            $error("ndc_array: unsupported parameters");
    end

    // Contents survive every reset, as a nonvolatile array would
    logic [DATA_W-1:0] store_q [DEPTH];
    logic busy_q, busy_d;
    logic done_q, done_d;
    logic commit;
    logic [CNT_W-1:0] cnt_q, cnt_d;
    logic [IDX_W-1:0] idx_q, idx_d;
    logic [DATA_W-1:0] data_q, data_d;

    always_comb
    begin
        busy_d = busy_q;
        cnt_d = cnt_q;
        idx_d = idx_q;
        data_d = data_q;
        done_d = 1'b0;
        commit = 1'b0;
        if (busy_q)
        begin
            if (mem.abort)
                busy_d = 1'b0;
            else if (cnt_q == '0)
            begin
                busy_d = 1'b0;
                done_d = 1'b1;
                commit = 1'b1;
            end
            else
                cnt_d = cnt_q - 1'b1;
        end
        else if (mem.start)
        begin
            // Index and byte are latched here, so later register edits do no harm
            busy_d = 1'b1;
            cnt_d = CNT_W'(WRITE_CYCLES_P - 1);
            idx_d = mem.index;
            data_d = mem.wdata;
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            busy_q <= 1'b0;
            done_q <= 1'b0;
            cnt_q <= '0;
            idx_q <= '0;
            data_q <= '0;
        end
        else
        begin
            busy_q <= busy_d;
            done_q <= done_d;
            cnt_q <= cnt_d;
            idx_q <= idx_d;
            data_q <= data_d;
        end
    end

    always_ff @(posedge clk)
    begin
        if (commit)
            store_q[idx_q] <= data_q;
    end

    assign mem.rdata = store_q[mem.index];
    assign mem.busy = busy_q;
    assign mem.done = done_q;

endmodule

`default_nettype wire

// ==== logic/ndc_ctrl.sv ====
/*
 * Data EEPROM access controller: control register, unlock detector,
 * index and value registers, completion and error flags, AHB-Lite slave.
 * Assumes one AHB-Lite master, word transfers, and a warm_reset pulse on
 * the same clock from the device's reset controller for non-power resets.
 */
// The AHB-Lite slave port was chosen for this implementation.
// Notes on behaviour
// RULE1: control bit 7 selects memory space
// RULE2: control bits 6 to 4 read zero
// RULE3: read strobe self-clears; writing zero ignored
// RULE4: firmware loads index, clears select first
// RULE5: read byte present on the next cycle
// RULE6: value register holds until read or write
// RULE7: firmware loads index and value before writing
// RULE8: 55h, AAh, then write strobe starts write
// RULE9: write strobe blocked while permit bit clear
// RULE10: hardware never clears the permit bit
// RULE11: clearing permit never disturbs a started write
// RULE12: write end clears strobe, sets done flag
// RULE13: done flag stays until software clears it
// RULE14: firmware masks interrupts across unlock sequence
// RULE15: firmware keeps permit clear except updating
// RULE16: firmware waits for write strobe clear
// RULE17: firmware keeps index within array size
// RULE18: reset during write sets error flag
// RULE19: unlock port stores nothing, reads zero
// RULE20: write strobe with select set does nothing
`timescale 1ns/10ps
`default_nettype none

module ndc_ctrl
#(
    parameter int unsigned WRITE_CYCLES_P = ndc_pkg::WRITE_CYCLES
)
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic warm_reset,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp
);
    import ndc_pkg::*;

    initial
    begin
        if (WRITE_CYCLES_P < 1)
            $error("ndc_ctrl: write cycle count must be at least one");
    end

    // ************************************************************
    // Reset release
    // ************************************************************
    logic rst_meta_q;
    logic rst_n;

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            rst_meta_q <= 1'b0;
            rst_n <= 1'b0;
        end
        else
        begin
            rst_meta_q <= 1'b1;
            rst_n <= rst_meta_q;
        end
    end

    // ************************************************************
    // Bus address phase capture
    // ************************************************************
    logic dp_valid_q, dp_valid_d;
    logic dp_write_q, dp_write_d;
    logic [13:0] dp_addr_q, dp_addr_d;
    logic take;

    // Size is not checked: the master issues whole words only
    assign take = hsel && hready && htrans[1];

    always_comb
    begin
        dp_valid_d = take;
        dp_write_d = dp_write_q;
        dp_addr_d = dp_addr_q;
        if (take)
        begin
            dp_write_d = hwrite;
            // Addresses above the map decode to nothing
            dp_addr_d = (haddr[31:14] == '0) ? haddr[13:0] : 14'h3FFF;
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            dp_valid_q <= 1'b0;
            dp_write_q <= 1'b0;
            dp_addr_q <= 14'h0000;
        end
        else
        begin
            dp_valid_q <= dp_valid_d;
            dp_write_q <= dp_write_d;
            dp_addr_q <= dp_addr_d;
        end
    end

    logic wr_en;
    logic [7:0] wd;

    assign wr_en = dp_valid_q && dp_write_q;
    assign wd = hwdata[7:0];

    // ************************************************************
    // Array
    // ************************************************************
    ndc_mem_if #(.IDX_W(IDX_W), .DATA_W(DATA_W)) mem ();

    ndc_array #(
        .WRITE_CYCLES_P(WRITE_CYCLES_P)
    ) u_array (
        .clk(clk),
        .rst_n(rst_n),
        .mem(mem)
    );

    // ************************************************************
    // Register state
    // ************************************************************
    ndc_unlock_t unlock_q, unlock_d;
    logic select_q, select_d;
    logic permit_q, permit_d;
    logic error_q, error_d;
    logic done_q, done_d;
    logic [7:0] value_q, value_d;
    logic [7:0] index_q, index_d;
    logic start;

    always_comb
    begin
        unlock_d = unlock_q;
        select_d = select_q;
        permit_d = permit_q;
        error_d = error_q;
        done_d = done_q;
        value_d = value_q;
        index_d = index_q;
        start = 1'b0;
        if (wr_en)
        begin
            // Any other write between keys and strobe breaks the sequence
            unlock_d = UNL_IDLE; // [RULE8]
            case (dp_addr_q)
                ADDR_UNLOCK:
                begin
                    // No storage behind this port, only the detector
                    if (wd == KEY_FIRST) // [RULE19]
                        unlock_d = UNL_FIRST; // [RULE8]
                    else if (wd == KEY_SECOND && unlock_q == UNL_FIRST)
                        unlock_d = UNL_ARMED; // [RULE8]
                end
                ADDR_CONTROL:
                begin
                    select_d = wd[BIT_SELECT]; // [RULE1]
                    // Only software and warm_reset reach this bit
                    permit_d = wd[BIT_PERMIT]; // [RULE10]
                    error_d = wd[BIT_ERROR];
                    // Read loads the value at once; no strobe state kept
                    if (wd[BIT_READ] && !wd[BIT_SELECT]) // [RULE3]
                        value_d = mem.rdata; // [RULE5]
                    // Select set drops the strobe with no action
                    if (wd[BIT_WRITE] && !wd[BIT_SELECT] && permit_q // [RULE9] [RULE20]
                        && unlock_q == UNL_ARMED && !mem.busy) // [RULE8]
                        start = 1'b1;
                end
                ADDR_VALUE_LOW:
                    value_d = wd; // [RULE6]
                ADDR_INDEX_LOW:
                    index_d = wd;
                ADDR_DONE:
                begin
                    if (!wd[BIT_DONE])
                        done_d = 1'b0; // [RULE13]
                end
                default:
                begin
                end
            endcase
        end
        if (warm_reset)
        begin
            unlock_d = UNL_IDLE;
            select_d = SELECT_RESET;
            permit_d = PERMIT_RESET;
            done_d = DONE_RESET;
            value_d = VALUE_RESET;
            index_d = INDEX_RESET;
            start = 1'b0;
            if (mem.busy)
                error_d = 1'b1; // [RULE18]
        end
        // Completion wins over a software clear in the same cycle; warm_reset wins over completion
        if (mem.done && !warm_reset)
            done_d = 1'b1; // [RULE12] [RULE13]
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            unlock_q <= UNL_IDLE;
            select_q <= SELECT_RESET;
            permit_q <= PERMIT_RESET;
            error_q <= ERROR_RESET;
            done_q <= DONE_RESET;
            value_q <= VALUE_RESET;
            index_q <= INDEX_RESET;
        end
        else
        begin
            unlock_q <= unlock_d;
            select_q <= select_d;
            permit_q <= permit_d;
            error_q <= error_d;
            done_q <= done_d;
            value_q <= value_d;
            index_q <= index_d;
        end
    end

    // Index and byte are latched by the array at start, so permit is not looked at
    assign mem.start = start; // [RULE11]
    assign mem.abort = warm_reset;
    assign mem.index = index_q[IDX_W-1:0];
    assign mem.wdata = value_q;

    // ************************************************************
    // Read data
    // ************************************************************
    logic [7:0] rd_byte;

    always_comb
    begin
        rd_byte = 8'h00;
        if (dp_valid_q && !dp_write_q)
        begin
            case (dp_addr_q)
                // Strobe bit shows busy and clears itself at write end
                ADDR_CONTROL:
                    rd_byte = {select_q, 3'h0, error_q, permit_q, mem.busy, 1'b0}; // [RULE2] [RULE12] [RULE3]
                ADDR_VALUE_LOW:
                    rd_byte = value_q;
                ADDR_INDEX_LOW:
                    rd_byte = index_q;
                ADDR_DONE:
                    rd_byte = {done_q, 7'h00};
                default:
                    rd_byte = 8'h00; // [RULE19]
            endcase
        end
    end

    assign hrdata = {24'h000000, rd_byte};
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

endmodule

`default_nettype wire

// ==== test/ndc_ctrl_checker.sv ====
/*
 * Port-level properties of the data EEPROM access controller.
 * Assumes single word transfers with hready tied to hreadyout.
 */
`timescale 1ns/10ps
`default_nettype none

module ndc_ctrl_checker
    import ndc_pkg::*;
#(
    parameter int unsigned WRITE_CYCLES_P = ndc_pkg::WRITE_CYCLES
)
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic warm_reset,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic [31:0] hrdata,
    input wire logic hresp
);
    logic ra_d, ra_q, rc_d, rc_q, rd_d, rd_q, ru_d, ru_q, wc_d, wc_q, wn_d, wn_q;

    // ************************************************************
    // Data phase trackers
    // ************************************************************
    always_comb
    begin
        ra_d = hsel && hready && htrans[1] && !hwrite;
        wc_d = hsel && hready && htrans[1] && hwrite && haddr == {18'h0, ADDR_CONTROL};
        rc_d = ra_d && haddr == {18'h0, ADDR_CONTROL};
        rd_d = ra_d && haddr == {18'h0, ADDR_DONE};
        ru_d = ra_d && haddr == {18'h0, ADDR_UNLOCK};
        wn_d = hsel && hready && htrans[1] && hwrite && haddr == {18'h0, ADDR_DONE};
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            {ra_q, rc_q, rd_q, ru_q, wc_q, wn_q} <= 6'h00;
        end
        else
        begin
            {ra_q, rc_q, rd_q, ru_q, wc_q, wn_q} <= {ra_d, rc_d, rd_d, ru_d, wc_d, wn_d};
        end
    end

    // ************************************************************
    // Properties
    // ************************************************************
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!resetn);

    sequence s_ctrl_idle;
        rc_q && !hrdata[BIT_WRITE];
    endsequence
    sequence s_sel_start;
        wc_q && hwdata[BIT_SELECT] && hwdata[BIT_WRITE];
    endsequence
    // Single transfers: one data phase every second cycle
    sequence s_sel_try;
        s_ctrl_idle ##2 s_sel_start ##2 rc_q;
    endsequence
    sequence s_done_kept;
        rd_q && hrdata[BIT_DONE] && !warm_reset ##1 !wn_q && !warm_reset ##1 rd_q;
    endsequence
    sequence s_permit_kept;
        rc_q && hrdata[BIT_PERMIT] && !warm_reset ##1 !wc_q && !warm_reset ##1 rc_q;
    endsequence

    a_ready_high: assert property (hreadyout && !hresp) else $error("slave not ready or not okay");
    a_idle_zero: assert property (!ra_q |-> hrdata == 32'h0) else $error("read data outside phase");
    a_lane_zero: assert property (ra_q |-> hrdata[31:8] == 24'h0) else $error("upper lanes set");
    a_ctrl_unimpl: assert property (rc_q |-> hrdata[6:4] == 3'h0) else $error("bits 6-4 set");
    a_read_selfclr: assert property (rc_q |-> !hrdata[BIT_READ]) else $error("read strobe stuck");
    a_unlock_nostore: assert property (ru_q |-> hrdata == 32'h0) else $error("unlock port readable");
    a_select_blocks: assert property (s_sel_try |-> !hrdata[BIT_WRITE])
        else $error("strobe with select set");
    a_done_sticky: assert property (s_done_kept |-> hrdata[BIT_DONE])
        else $error("done flag dropped");
    a_permit_kept: assert property (s_permit_kept |-> hrdata[BIT_PERMIT])
        else $error("permit cleared by hardware");
endmodule

bind ndc_ctrl ndc_ctrl_checker #(.WRITE_CYCLES_P(WRITE_CYCLES_P)) ndc_ctrl_checker_i (.clk(clk),
    .resetn(resetn), .warm_reset(warm_reset), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
    .hrdata(hrdata), .hresp(hresp));

`default_nettype wire

// ==== test/ndc_ctrl_bench.sv ====
/*
 * Self-checking bench for the data EEPROM access controller.
 * Assumes a zero-wait AHB-Lite slave; the bench is the only master.
 */
`timescale 1ns/10ps
`default_nettype none

module ndc_ctrl_bench;
    import ndc_pkg::*;
    // Short write time keeps the run brief
    localparam int unsigned WC = 8;
    logic clk, resetn, warm_reset, hsel, hwrite, hreadyout, hresp;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [7:0] r, la, ld, k1, k2, cv;
    logic [13:0] ra [4] = '{ADDR_DONE, ADDR_VALUE_LOW, ADDR_INDEX_LOW, 14'h0040};
    int err_total, checks_done;
    wire hready = hreadyout;

    ndc_ctrl #(.WRITE_CYCLES_P(WC)) ndc_ctrl_i (.clk(clk), .resetn(resetn),
        .warm_reset(warm_reset), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
        .hrdata(hrdata), .hresp(hresp));

    always #2.5 clk = ~clk;

    function automatic logic [7:0] ctl(input logic s, input logic e, input logic p,
        input logic w);
        return {s, 3'h0, e, p, w, 1'b0};
    endfunction

    task chk(input logic [7:0] seen, input logic [7:0] exp, input string what);
        checks_done++;
        if (seen !== exp)
        begin
            err_total++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // Single transfer: address held until ready, then idle with data; read data at the end
    task xfer(input logic w, input logic [13:0] a, input logic [7:0] d);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {18'h0, a};
        do
            @(posedge clk);
        while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= {24'h0, d};
        do
            @(posedge clk);
        while (hready !== 1'b1);
        r = hrdata[7:0];
    endtask

    task wr(input logic [13:0] a, input logic [7:0] d);
        xfer(1'b1, a, d);
    endtask

    task rd(input logic [13:0] a, input logic [7:0] e, input string n);
        xfer(1'b0, a, 8'h00);
        chk(r, e, n);
    endtask

    task go_write(input logic [7:0] i, input logic [7:0] d, input logic b, input logic [7:0] c);
        wr(ADDR_INDEX_LOW, i);
        wr(ADDR_VALUE_LOW, d);
        wr(ADDR_UNLOCK, k1);
        if (b)
            wr(ADDR_INDEX_LOW, i);
        wr(ADDR_UNLOCK, k2);
        wr(ADDR_CONTROL, c);
    endtask

    task read_op(input logic [7:0] i, input logic [7:0] e);
        wr(ADDR_VALUE_LOW, ~e);
        wr(ADDR_INDEX_LOW, i);
        wr(ADDR_CONTROL, 8'h01);
        rd(ADDR_VALUE_LOW, e, "value");
        rd(ADDR_VALUE_LOW, e, "value");
    endtask

    task summarize;
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    initial
    begin
        #100000;
        err_total++;
        summarize;
    end

    initial
    begin
        clk = 1'b0;
        {resetn, warm_reset, hsel, hwrite, htrans, haddr, hwdata} = '0;
        hsize = 3'h2;
        err_total = 0;
        checks_done = 0;
        void'($urandom(32'h2539));
        repeat (2) @(posedge clk);
        resetn <= 1'b1;
        repeat (3) @(posedge clk);
        wr(14'h0040, 8'hFF);
        foreach (ra[j])
            rd(ra[j], 8'h00, "reset");
        rd(ADDR_CONTROL, 8'h00, "control");
        rd(ADDR_UNLOCK, 8'h00, "unlock");
        $display("test reset finished");
        repeat (4)
        begin
            la = $urandom;
            ld = $urandom;
            wr(ADDR_INDEX_LOW, la);
            rd(ADDR_INDEX_LOW, la, "index");
            wr(ADDR_CONTROL, ld & 8'hFC);
            rd(ADDR_CONTROL, ctl(ld[7], ld[3], ld[2], 1'b0), "control");
        end
        wr(ADDR_CONTROL, 8'h04);
        $display("test registers finished");
        k1 = KEY_FIRST;
        k2 = KEY_SECOND;
        for (int i = 0; i < 4; i++)
        begin
            la = $urandom;
            ld = (i == 0) ? 8'hFF : $urandom;
            go_write(la, ld, 1'b0, 8'h06);
            rd(ADDR_CONTROL, ctl(1'b0, 1'b0, 1'b1, 1'b1), "busy");
            if (i[0])
            begin
                wr(ADDR_CONTROL, 8'h00);
                rd(ADDR_CONTROL, ctl(1'b0, 1'b0, 1'b0, 1'b1), "busy");
            end
            repeat (WC) @(posedge clk);
            rd(ADDR_CONTROL, ctl(1'b0, 1'b0, !i[0], 1'b0), "idle");
            rd(ADDR_DONE, 8'h80, "done");
            rd(ADDR_DONE, 8'h80, "done");
            wr(ADDR_DONE, 8'h00);
            rd(ADDR_DONE, 8'h00, "done");
            read_op(la, ld);
            wr(ADDR_CONTROL, 8'h04);
        end
        // Keys armed and a read between, so only select can block the strobe
        wr(ADDR_UNLOCK, KEY_FIRST);
        wr(ADDR_UNLOCK, KEY_SECOND);
        rd(ADDR_CONTROL, ctl(1'b0, 1'b0, 1'b1, 1'b0), "control");
        wr(ADDR_CONTROL, 8'h86);
        rd(ADDR_CONTROL, ctl(1'b1, 1'b0, 1'b1, 1'b0), "select");
        rd(ADDR_CONTROL, ctl(1'b1, 1'b0, 1'b1, 1'b0), "select");
        $display("test writes finished");
        for (int i = 0; i < 5; i++)
        begin
            {k1, k2, cv} = (i == 0) ? {KEY_SECOND, KEY_FIRST, 8'h06} :
                (i == 1) ? {KEY_FIRST, KEY_FIRST, 8'h06} :
                (i == 2) ? {KEY_FIRST, KEY_SECOND, 8'h86} : {KEY_FIRST, KEY_SECOND, 8'h02};
            wr(ADDR_CONTROL, (i == 3) ? 8'h00 : 8'h04);
            go_write(la, ~ld, i == 4, cv);
            rd(ADDR_CONTROL, ctl(cv[7], 1'b0, cv[2], 1'b0), "blocked");
            repeat (WC) @(posedge clk);
            rd(ADDR_DONE, 8'h00, "done");
            read_op(la, ld);
        end
        $display("test locks finished");
        wr(ADDR_CONTROL, 8'h04);
        {k1, k2} = {KEY_FIRST, KEY_SECOND};
        go_write(la, ~ld, 1'b0, 8'h06);
        warm_reset <= 1'b1;
        @(posedge clk);
        warm_reset <= 1'b0;
        @(posedge clk);
        rd(ADDR_CONTROL, ctl(1'b0, 1'b1, 1'b0, 1'b0), "error");
        repeat (WC) @(posedge clk);
        rd(ADDR_CONTROL, ctl(1'b0, 1'b1, 1'b0, 1'b0), "error");
        rd(ADDR_DONE, 8'h00, "done");
        read_op(la, ld);
        // The read strobe write carries error bit zero, and software may clear it
        rd(ADDR_CONTROL, ctl(1'b0, 1'b0, 1'b0, 1'b0), "error");
        $display("test abort finished");
        summarize;
    end
endmodule

`default_nettype wire
